// File: hw/tafc_pkg.sv
// package: register map, field layouts and constants for the alert filter config block
package tafc_pkg;
	// ==================================================
	// register pointers
	localparam logic [7:0] PTR_ALERT_CFG = 8'h22;
	localparam logic [7:0] PTR_IDEALITY = 8'h23;
	localparam logic [7:0] PTR_AVG_CFG = 8'h24;
	localparam logic [7:0] PTR_MAKER_ID = 8'hfe;
	// ==================================================
	// reset values
	localparam logic [7:0] RST_ALERT_CFG = 8'h01;
	localparam logic [7:0] RST_IDEALITY = 8'h00;
	localparam logic [7:0] RST_AVG_CFG = 8'h00;
	// arbitrary neutral identification value
	localparam logic [7:0] MAKER_CODE_DEFAULT = 8'ha7;
	// ==================================================
	// field positions and masks
	localparam int TIMEOUT_BIT = 7;
	localparam int REPEAT_LSB = 1;
	localparam int REPEAT_MSB = 3;
	localparam logic [7:0] ALERT_CFG_MASK = 8'h8f;
	localparam logic [7:0] AVG_CFG_MASK = 8'h03;
	// ==================================================
	// repeat codes and averaging codes
	localparam logic [2:0] REPEAT_1 = 3'h0;
	localparam logic [2:0] REPEAT_2 = 3'h1;
	localparam logic [2:0] REPEAT_3 = 3'h3;
	localparam logic [2:0] REPEAT_4 = 3'h7;
	localparam logic [1:0] AVG_OFF = 2'h0;
	localparam logic [1:0] AVG_4 = 2'h1;
	localparam logic [1:0] AVG_8 = 2'h2;
	// ==================================================
	// ideality arithmetic: eta_eff = 1.008*2088/(2088+n), 16-bit fraction
	localparam int IDEAL_BASE = 2088;
	localparam logic [31:0] ETA_NOMINAL_Q16 = 32'h0001_020c;
	localparam logic [47:0] ETA_NUMER_Q16 = 48'h0000_0838_b439;
endpackage

// File: hw/tafc_ideality.sv
// ideality correction: scales remote conversion by the effective factor divided by its 1.008 nominal
`timescale 1ns/10ps
module tafc_ideality (
	// clock and reset
	input wire logic clk_in,
	input wire logic reset_n_in,
	// settings and sample
	input wire logic [7:0] adjust_in,
	input wire logic remote_in,
	input wire logic [15:0] raw_in,
	// result
	output logic [15:0] corr_out
);
	typedef struct packed {
		logic [15:0] corr;
	} tafc_idl_state_t;
	tafc_idl_state_t state_r, state_nxt;
	logic signed [12:0] denom;
	logic [31:0] gain;
	logic [47:0] prod;
	// ==================================================
	// combinational
	always_comb
	begin
		denom = 13'(tafc_pkg::IDEAL_BASE) + 13'($signed(adjust_in)); // see RULE4
		// nominal gain is unity: divider drops out when adjust is zero
		// scaled in 48 bits, a 32-bit product of two q16 values would wrap
		gain = 32'(48'(tafc_pkg::ETA_NUMER_Q16 / 48'(unsigned'(denom)))
			* 48'h0000_0001_0000 / 48'(tafc_pkg::ETA_NOMINAL_Q16)); // see RULE5
		prod = 48'(raw_in) * 48'(gain);
		state_nxt = state_r;
		if (!remote_in || adjust_in == tafc_pkg::RST_IDEALITY) // see RULE8 see RULE6
			state_nxt.corr = raw_in;
		else
			state_nxt.corr = prod[31:16];
	end
	// ==================================================
	// registers
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			state_r <= '0;
		else
			state_r <= state_nxt;
	end
	assign corr_out = state_r.corr;
endmodule // tafc_ideality

// File: hw/tafc_average.sv
// remote result averaging over 1, 4 or 8 samples
`timescale 1ns/10ps
module tafc_average #(
	parameter int WIDTH = 16
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic reset_n_in,
	// control and sample
	input wire logic [1:0] select_in,
	input wire logic sample_valid_in,
	input wire logic [WIDTH-1:0] sample_in,
	// result
	output logic [WIDTH-1:0] avg_out,
	output logic avg_valid_out
);
	typedef struct packed {
		logic [WIDTH+2:0] sum;
		logic [2:0] cnt;
		logic [WIDTH-1:0] avg;
		logic vld;
	} tafc_avg_state_t;
	tafc_avg_state_t state_r, state_nxt;
	logic [WIDTH+2:0] acc;
	logic [2:0] last;
	// ==================================================
	// combinational
	always_comb
	begin
		state_nxt = state_r;
		state_nxt.vld = 1'b0;
		acc = state_r.sum + (WIDTH+3)'(sample_in);
		case (select_in) // see RULE9
			tafc_pkg::AVG_4: last = 3'h3;
			tafc_pkg::AVG_8: last = 3'h7;
			default: last = 3'h0;
		endcase
		if (sample_valid_in)
		begin
			if (state_r.cnt >= last)
			begin
				// block average: fewer adders than a running window
				case (select_in)
					tafc_pkg::AVG_4: state_nxt.avg = acc[WIDTH+1:2];
					tafc_pkg::AVG_8: state_nxt.avg = acc[WIDTH+2:3];
					default: state_nxt.avg = sample_in;
				endcase
				state_nxt.vld = 1'b1;
				state_nxt.sum = '0;
				state_nxt.cnt = '0;
			end
			else
			begin
				state_nxt.sum = acc;
				state_nxt.cnt = state_r.cnt + 3'h1;
			end
		end
	end
	// ==================================================
	// registers
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			state_r <= '0;
		else
			state_r <= state_nxt;
	end
	assign avg_out = state_r.avg;
	assign avg_valid_out = state_r.vld;
endmodule // tafc_average

// File: hw/tafc_top.sv
// top: pointer register file, alert qualification, remote correction path
// Overview of operation
// RULE1 - top bit of alert register enables bus timeout
// RULE2 - alert only after programmed consecutive violations
// RULE3 - alert register at 22h, resets 01h
// RULE4 - correction value is signed -128 to 127
// RULE5 - effective factor 1.008*2088/(2088+n)
// RULE6 - correction resets zero, zero means uncorrected
// RULE7 - correction read and written at 23h
// RULE8 - correction applies to remote channel only
// RULE9 - filter field at 24h selects averaging
// RULE10 - identification code returned at FEh
// RULE11 - identification register ignores writes
// RULE12 - host may read identification before use
// RULE13 - counter clears when measurement back in limits
`timescale 1ns/10ps
module tafc_top #(
	parameter logic [7:0] MAKER_CODE = tafc_pkg::MAKER_CODE_DEFAULT,
	parameter int TEMP_WIDTH = 16
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic reset_n_in,
	// pointer register access from serial interface
	input wire logic [7:0] reg_ptr_in,
	input wire logic reg_wr_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	// measurement results from converter
	input wire logic meas_valid_in,
	input wire logic meas_out_of_limit_in,
	input wire logic conv_valid_in,
	input wire logic conv_remote_in,
	input wire logic [TEMP_WIDTH-1:0] conv_raw_in,
	// alert and timeout
	output logic alert_out,
	output logic bus_timeout_enable_out,
	// results
	output logic [TEMP_WIDTH-1:0] local_temp_out,
	output logic [TEMP_WIDTH-1:0] remote_temp_out,
	output logic remote_valid_out
);
	typedef struct packed {
		logic [7:0] alert_cfg;
		logic [7:0] ideality;
		logic [7:0] avg_cfg;
		logic [2:0] run_cnt;
		logic alert;
		logic [7:0] rdata;
		logic conv_vld;
		logic conv_remote;
		logic [TEMP_WIDTH-1:0] local_temp;
	} tafc_state_t;
	tafc_state_t state_r, state_nxt;
	logic [2:0] alert_repeat_count;
	logic [2:0] need;
	logic [15:0] corr;
	logic [TEMP_WIDTH-1:0] avg;
	logic avg_vld;
	// ==================================================
	// correction and averaging
	tafc_ideality u_ideality (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.adjust_in(state_r.ideality),
		.remote_in(conv_remote_in),
		.raw_in(16'(conv_raw_in)),
		.corr_out(corr)
	);
	tafc_average #(
		.WIDTH(TEMP_WIDTH)
	) u_average (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.select_in(state_r.avg_cfg[1:0]),
		.sample_valid_in(state_r.conv_vld && state_r.conv_remote),
		.sample_in(TEMP_WIDTH'(corr)),
		.avg_out(avg),
		.avg_valid_out(avg_vld)
	);
	// ==================================================
	// combinational
	always_comb
	begin
		state_nxt = state_r;
		alert_repeat_count = state_r.alert_cfg[tafc_pkg::REPEAT_MSB:tafc_pkg::REPEAT_LSB];
		case (alert_repeat_count) // see RULE2
			tafc_pkg::REPEAT_2: need = 3'h2;
			tafc_pkg::REPEAT_3: need = 3'h3;
			tafc_pkg::REPEAT_4: need = 3'h4;
			default: need = 3'h1;
		endcase
		// register writes; id pointer has no write path
		if (reg_wr_in)
		begin
			case (reg_ptr_in)
				tafc_pkg::PTR_ALERT_CFG: state_nxt.alert_cfg =
					reg_wdata_in & tafc_pkg::ALERT_CFG_MASK; // see RULE3
				tafc_pkg::PTR_IDEALITY: state_nxt.ideality = reg_wdata_in; // see RULE7
				tafc_pkg::PTR_AVG_CFG: state_nxt.avg_cfg =
					reg_wdata_in & tafc_pkg::AVG_CFG_MASK; // see RULE9
				default: ; // see RULE11
			endcase
		end
		// reads, registered so data comes from flops
		case (reg_ptr_in)
			tafc_pkg::PTR_ALERT_CFG: state_nxt.rdata = state_r.alert_cfg; // see RULE3
			tafc_pkg::PTR_IDEALITY: state_nxt.rdata = state_r.ideality; // see RULE7
			tafc_pkg::PTR_AVG_CFG: state_nxt.rdata = state_r.avg_cfg;
			tafc_pkg::PTR_MAKER_ID: state_nxt.rdata = MAKER_CODE; // see RULE10
			default: state_nxt.rdata = 8'h00;
		endcase
		// consecutive violation counter saturates at the required count
		if (meas_valid_in)
		begin
			if (!meas_out_of_limit_in)
			begin
				state_nxt.run_cnt = 3'h0; // see RULE13
				state_nxt.alert = 1'b0;
			end
			else
			begin
				if (state_r.run_cnt < need)
					state_nxt.run_cnt = state_r.run_cnt + 3'h1;
				if (state_r.run_cnt + 3'h1 >= need) // see RULE2
					state_nxt.alert = 1'b1;
			end
		end
		state_nxt.conv_vld = conv_valid_in;
		state_nxt.conv_remote = conv_remote_in;
		if (state_r.conv_vld && !state_r.conv_remote)
			state_nxt.local_temp = TEMP_WIDTH'(corr); // see RULE8
	end
	// ==================================================
	// registers
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			state_r <= '0;
			state_r.alert_cfg <= tafc_pkg::RST_ALERT_CFG; // see RULE3
			state_r.ideality <= tafc_pkg::RST_IDEALITY; // see RULE6
			state_r.avg_cfg <= tafc_pkg::RST_AVG_CFG;
		end
		else
			state_r <= state_nxt;
	end
	// ==================================================
	// outputs
	assign reg_rdata_out = state_r.rdata;
	assign alert_out = state_r.alert;
	assign bus_timeout_enable_out = state_r.alert_cfg[tafc_pkg::TIMEOUT_BIT]; // see RULE1
	assign local_temp_out = state_r.local_temp;
	assign remote_temp_out = avg;
	assign remote_valid_out = avg_vld;
endmodule // tafc_top

// File: test/tafc_sva.sv
// checker: port assertions of the alert filter config block
`timescale 1ns/10ps
module tafc_sva #(
	parameter logic [7:0] MAKER_CODE = 8'h00
) (
	// watched ports
	input logic clk_in,
	input logic reset_n_in,
	input logic [7:0] reg_ptr_in,
	input logic reg_wr_in,
	input logic [7:0] reg_wdata_in,
	input logic [7:0] reg_rdata_out,
	input logic meas_valid_in,
	input logic meas_out_of_limit_in,
	input logic conv_valid_in,
	input logic conv_remote_in,
	input logic alert_out,
	input logic bus_timeout_enable_out,
	input logic remote_valid_out
);
	// ====
	// properties
	default clocking @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	id_read_a: assert property
		(reg_ptr_in == 8'hfe |=> reg_rdata_out == MAKER_CODE) else $error("bad id");
	read_back_a: assert property
		(reg_wr_in && reg_ptr_in == 8'h23 ##1 reg_ptr_in == 8'h23
		|=> reg_rdata_out == $past(reg_wdata_in, 2)) else $error("bad readback");
	avg_field_a: assert property
		(reg_ptr_in == 8'h24 |=> reg_rdata_out[7:2] == 6'h00) else $error("bad field");
	timeout_set_a: assert property
		(reg_wr_in && reg_ptr_in == 8'h22
		|=> bus_timeout_enable_out == $past(reg_wdata_in[7])) else $error("bad timeout");
	timeout_hold_a: assert property
		(!(reg_wr_in && reg_ptr_in == 8'h22) |=> $stable(bus_timeout_enable_out))
		else $error("timeout moved");
	alert_cause_a: assert property
		($rose(alert_out) |-> $past(meas_valid_in) && $past(meas_out_of_limit_in))
		else $error("alert without cause");
	alert_clear_a: assert property
		(meas_valid_in && !meas_out_of_limit_in |=> !alert_out) else $error("alert kept");
	remote_src_a: assert property
		(remote_valid_out |-> $past(conv_valid_in, 2) && $past(conv_remote_in, 2))
		else $error("remote without sample");
endmodule // tafc_sva
bind tafc_top tafc_sva #(.MAKER_CODE(MAKER_CODE)) tafc_sva_i (
	.clk_in(clk_in), .reset_n_in(reset_n_in), .reg_ptr_in(reg_ptr_in),
	.reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
	.meas_valid_in(meas_valid_in), .meas_out_of_limit_in(meas_out_of_limit_in),
	.conv_valid_in(conv_valid_in), .conv_remote_in(conv_remote_in), .alert_out(alert_out),
	.bus_timeout_enable_out(bus_timeout_enable_out), .remote_valid_out(remote_valid_out)
);

// File: test/tafc_host.sv
// host model: pointer, strobe and data toward the register port
`timescale 1ns/10ps
module tafc_host (
	// register port
	input logic clk_in,
	output logic [7:0] ptr_out = 8'h00,
	output logic wr_out = 1'b0,
	output logic [7:0] wdata_out = 8'h00,
	input logic [7:0] rdata_in
);
	// ====
	// transfers
	// data inverted after release so a stale byte never looks valid
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		@(negedge clk_in);
		ptr_out = p;
		wdata_out = d;
		wr_out = 1'b1;
		@(negedge clk_in);
		wr_out = 1'b0;
		wdata_out = ~d;
	endtask
	task automatic rd(input logic [7:0] p, output logic [7:0] d);
		@(negedge clk_in);
		ptr_out = p;
		@(negedge clk_in);
		d = rdata_in;
	endtask
endmodule // tafc_host

// File: test/tb_tafc_top.sv
// testbench: register, alert and conversion checks against a bench model
`timescale 1ns/10ps
module tb_tafc_top;
	// ====
	// stimulus and model state
	logic clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic mv = 1'b0, mo = 1'b0, cv = 1'b0, cr = 1'b0;
	logic [7:0] ptr, wdata, rdata, d;
	logic wr, alert, tmo, rv;
	logic [15:0] raw = 16'h0000;
	logic [15:0] lt, rt, v;
	logic [31:0] lf = 32'h0001_3ae7;
	logic [7:0] ap[5] = '{8'h22, 8'h23, 8'h24, 8'hfe, 8'h30};
	logic [7:0] ar[5] = '{8'h01, 8'h00, 8'h00, tafc_pkg::MAKER_CODE_DEFAULT, 8'h00};
	logic [7:0] aw[5] = '{8'h8f, 8'hff, 8'h03, tafc_pkg::MAKER_CODE_DEFAULT, 8'h00};
	logic [7:0] aj[3] = '{8'h7f, 8'h80, 8'h00};
	int cd[4] = '{0, 1, 3, 7};
	int an[4] = '{1, 4, 8, 1};
	int n_errors = 0;
	int check_count = 0;
	int cnt, k, i, t, e;
	always #10 clk_in = ~clk_in;
	tafc_host tafc_host_i (.clk_in(clk_in), .ptr_out(ptr), .wr_out(wr), .wdata_out(wdata),
		.rdata_in(rdata));
	tafc_top tafc_top_i (.clk_in(clk_in), .reset_n_in(reset_n_in), .reg_ptr_in(ptr),
		.reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .meas_valid_in(mv),
		.meas_out_of_limit_in(mo), .conv_valid_in(cv), .conv_remote_in(cr), .conv_raw_in(raw),
		.alert_out(alert), .bus_timeout_enable_out(tmo), .local_temp_out(lt),
		.remote_temp_out(rt), .remote_valid_out(rv));
	// ====
	// helpers
	function automatic logic [31:0] nx(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic meas(input logic o);
		@(negedge clk_in);
		mv = 1'b1;
		mo = o;
		@(negedge clk_in);
		mv = 1'b0;
		mo = ~o;
	endtask
	task automatic conv(input logic r, input logic [15:0] x);
		@(negedge clk_in);
		cv = 1'b1;
		cr = r;
		raw = x;
		@(negedge clk_in);
		cv = 1'b0;
		raw = ~x;
	endtask
	task automatic wait_rv();
		for (t = 0; t < 20 && rv !== 1'b1; t++)
			@(negedge clk_in);
		if (t == 20)
		begin
			n_errors++;
			give_verdict();
		end
	endtask
	// ====
	// main sequence
	initial
	begin
		repeat (8) @(negedge clk_in);
		reset_n_in = 1'b1;
		for (k = 0; k < 5; k++)
		begin
			tafc_host_i.rd(ap[k], d);
			chk(d, ar[k]);
			tafc_host_i.wr(ap[k], 8'hff);
			tafc_host_i.rd(ap[k], d);
			chk(d, aw[k]);
		end
		$display("test registers done");
		// counter is not cleared by a config write, so the model carries it over
		cnt = 0;
		for (k = 0; k < 4; k++)
		begin
			tafc_host_i.wr(8'h22, {k[0], 3'h0, 3'(cd[k]), 1'b1});
			chk(tmo, k[0]);
			repeat (24)
			begin
				lf = nx(lf);
				meas(lf[0] | lf[1]);
				cnt = (lf[0] | lf[1]) ? cnt + 1 : 0;
				chk(alert, cnt > k);
			end
		end
		$display("test alert done");
		tafc_host_i.wr(8'h24, 8'h00);
		for (k = 0; k < 3; k++)
		begin
			tafc_host_i.wr(8'h23, aj[k]);
			lf = nx(lf);
			v = {1'b0, lf[14:0]};
			conv(1'b1, v);
			wait_rv();
			e = int'(v) * 2088 / (2088 + int'($signed(aj[k]))) - int'(rt);
			chk({^rt === 1'bx, e * e <= 4}, 2'b01);
			if (k == 2)
				chk(rt, v);
			conv(1'b0, v);
			@(negedge clk_in);
			chk(lt, v);
		end
		for (k = 0; k < 4; k++)
		begin
			tafc_host_i.wr(8'h24, 8'(k));
			e = 0;
			for (i = 0; i < an[k]; i++)
			begin
				lf = nx(lf);
				conv(1'b1, lf[15:0]);
				e += lf[15:0];
			end
			wait_rv();
			chk(rt, e / an[k]);
		end
		$display("test conversion done");
		give_verdict();
	end
endmodule // tb_tafc_top
